// file: shared/irqx_map.svh
// constant map of the grouped interrupt expander
`ifndef IRQX_MAP_SVH
`define IRQX_MAP_SVH

// ************************************************************
// sizes
// ************************************************************
`define IRQX_NUM_IRQ          96
`define IRQX_NUM_GROUPS       12
`define IRQX_GROUP_SIZE       8
`define IRQX_IDX_W            7
`define IRQX_LINE_W           4

// connected positions, bit 0 = group 1 position 1 (72 bits set)
`define IRQX_CONNECTED_MASK   96'hFB0F_FF03_03FF_F3C7_FFFF_FFDB

// ************************************************************
// vector memory layout (word addresses)
// ************************************************************
`define IRQX_VEC_BASE         16'h0D40
`define IRQX_VEC_LAST         16'h0DFE
`define IRQX_ADDR_W           16

// ************************************************************
// timing
// ************************************************************
`define IRQX_FETCH_MAX_CYC    8

// ************************************************************
// fixed source positions (flat index = 8*(group-1) + position-1)
// ************************************************************
`define IRQX_IDX_CONV_A       7'h00
`define IRQX_IDX_CONV_B       7'h01
`define IRQX_IDX_EXT_A        7'h03
`define IRQX_IDX_EXT_B        7'h04
`define IRQX_IDX_TIMER        7'h06
`define IRQX_IDX_WAKE         7'h07
`define IRQX_IDX_TRIP_BASE    7'h08
`define IRQX_IDX_EVENT_BASE   7'h10
`define IRQX_IDX_FPU_OVF      7'h5E
`define IRQX_IDX_FPU_UNF      7'h5F

`endif

// file: shared/irqx_pkg.sv
// types shared by the grouped interrupt expander
package irqx_pkg;
    // service sequencer states
    typedef enum logic [0:0] {
        ST_IDLE,
        ST_FETCH
    } irqx_state_t;
endpackage

// file: logic/irqx_vector_ram.sv
// flip-flop vector storage, one entry per interrupt input
`timescale 1ns/1ps
`include "irqx_map.svh"

module irqx_vector_ram #(
    parameter int DEPTH = `IRQX_NUM_IRQ,
    parameter int VEC_W = 32
) (
    input  wire logic                    core_clk,
    input  wire logic                    reset_n,
    input  wire logic                    wr_en,
    input  wire logic [`IRQX_IDX_W-1:0]  wr_idx,
    input  wire logic [VEC_W-1:0]        wr_data,
    input  wire logic                    rd_en,
    input  wire logic [`IRQX_IDX_W-1:0]  rd_idx,
    output logic      [VEC_W-1:0]        rd_data
);

    // ************************************************************
    // storage
    // ************************************************************
    logic [VEC_W-1:0] mem_q [DEPTH];   // vector entries
    logic [VEC_W-1:0] rd_data_q;       // registered read word

    // write port, cleared on reset so every entry is defined
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else if (wr_en) begin
            mem_q[wr_idx] <= wr_data;
        end
    end

    // synchronous read, old data on a same-cycle write
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            rd_data_q <= '0;
        end else if (rd_en) begin
            rd_data_q <= mem_q[rd_idx];
        end
    end

    assign rd_data = rd_data_q;

endmodule

// file: logic/irqx_expander.sv
// grouped peripheral interrupt expander: 96 inputs onto 12 processor lines
`timescale 1ns/1ps
`include "irqx_map.svh"

module irqx_expander #(
    parameter int VEC_W = 32
) (
    input  wire logic                       core_clk,
    input  wire logic                       reset_n,
    input  wire logic                       converter_irq_a,
    input  wire logic                       converter_irq_b,
    input  wire logic                       ext_pin_irq_a,
    input  wire logic                       ext_pin_irq_b,
    input  wire logic                       first_timer_irq,
    input  wire logic                       low_power_wake_irq,
    input  wire logic [7:0]                 modulator_trip_irq,
    input  wire logic [7:0]                 modulator_event_irq,
    input  wire logic                       fpu_overflow_event,
    input  wire logic                       fpu_underflow_event,
    input  wire logic [`IRQX_NUM_IRQ-1:0]   other_periph_irq,
    input  wire logic                       second_timer_irq,
    input  wire logic                       third_timer_irq,
    input  wire logic                       direct_nmi_irq,
    input  wire logic [`IRQX_NUM_IRQ-1:0]   irq_enable,
    input  wire logic                       sw_set_valid,
    input  wire logic [`IRQX_NUM_IRQ-1:0]   sw_set_mask,
    input  wire logic                       vec_wr_en,
    input  wire logic [`IRQX_ADDR_W-1:0]    vec_wr_addr,
    input  wire logic [VEC_W-1:0]           vec_wr_data,
    input  wire logic                       svc_req,
    input  wire logic [`IRQX_LINE_W-1:0]    svc_line,
    output logic      [`IRQX_NUM_GROUPS-1:0] grouped_cpu_irq_lines,
    output logic      [`IRQX_NUM_IRQ-1:0]   group_pending_flags,
    output logic                            timer2_irq_to_cpu,
    output logic                            timer3_irq_to_cpu,
    output logic                            nmi_irq_to_cpu,
    output logic                            top_line_valid,
    output logic      [`IRQX_LINE_W-1:0]    top_line,
    output logic                            vec_valid,
    output logic                            vec_none,
    output logic      [VEC_W-1:0]           vec_data,
    output logic      [`IRQX_IDX_W-1:0]     vec_source
);

    localparam int FETCH_MAX_C = `IRQX_FETCH_MAX_CYC;

    // ************************************************************
    // helper functions
    // ************************************************************
    // lowest set bit of a 16-bit vector, zero when none
    function automatic logic [3:0] lowest_index(input logic [15:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 15; i >= 0; i--) begin
            if (v[i]) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    // word address to entry index, two words per entry
    function automatic logic [`IRQX_IDX_W:0] addr_to_idx(input logic [`IRQX_ADDR_W-1:0] a);
        logic [`IRQX_ADDR_W-1:0] off;
        off = a - `IRQX_VEC_BASE;
        addr_to_idx = {(a >= `IRQX_VEC_BASE) && (a <= `IRQX_VEC_LAST) && !a[0],
                       off[`IRQX_IDX_W:1]};
    endfunction

    // ************************************************************
    // declarations
    // ************************************************************
    logic [`IRQX_NUM_IRQ-1:0]    src;            // mapped source levels
    logic [`IRQX_NUM_IRQ-1:0]    src_prev_q;     // previous source levels
    logic [`IRQX_NUM_IRQ-1:0]    pend_set;       // new requests this cycle
    logic [`IRQX_NUM_IRQ-1:0]    pend_clr;       // fetch clear this cycle
    logic [`IRQX_NUM_IRQ-1:0]    pend_q;         // pending flags
    logic [`IRQX_NUM_IRQ-1:0]    live;           // pending and enabled
    logic [`IRQX_NUM_GROUPS-1:0] group_any;      // per-group request
    logic [`IRQX_NUM_GROUPS-1:0] lines_q;        // registered group lines
    logic [7:0]                  line_bits;      // live bits of serviced line
    logic                        line_ok;        // serviced line in range
    logic [2:0]                  sel_pos;        // chosen position in line
    logic [`IRQX_IDX_W-1:0]      sel_idx;        // chosen flat index
    logic                        take;           // service accepted with a source
    logic [`IRQX_IDX_W:0]        wr_dec;         // decoded write address
    logic [VEC_W-1:0]            ram_data;       // vector read data
    irqx_pkg::irqx_state_t       state_q;        // service sequencer
    logic [`IRQX_IDX_W-1:0]      src_idx_q;      // index being fetched
    logic                        vec_valid_q;
    logic                        vec_none_q;
    logic [VEC_W-1:0]            vec_data_q;
    logic [`IRQX_IDX_W-1:0]      vec_source_q;
    logic                        top_valid_q;
    logic [`IRQX_LINE_W-1:0]     top_line_q;
    logic                        t2_q;
    logic                        t3_q;
    logic                        nmi_q;

    // ************************************************************
    // source mapping
    // ************************************************************
    // fixed assignment overlays the generic inputs; fpu events are ordinary sources
    always_comb begin
        src = other_periph_irq;
        src[`IRQX_IDX_EVENT_BASE + 7'h07 : 0] = '0;
        src[`IRQX_IDX_CONV_A] = converter_irq_a;
        src[`IRQX_IDX_CONV_B] = converter_irq_b;
        src[`IRQX_IDX_EXT_A]  = ext_pin_irq_a;
        src[`IRQX_IDX_EXT_B]  = ext_pin_irq_b;
        src[`IRQX_IDX_TIMER]  = first_timer_irq;
        src[`IRQX_IDX_WAKE]   = low_power_wake_irq;
        src[`IRQX_IDX_TRIP_BASE +: 8]  = modulator_trip_irq;
        src[`IRQX_IDX_EVENT_BASE +: 8] = modulator_event_irq;
        src[`IRQX_IDX_FPU_OVF] = fpu_overflow_event;
        src[`IRQX_IDX_FPU_UNF] = fpu_underflow_event;
        src = src & `IRQX_CONNECTED_MASK;
    end

    // previous levels for rising-edge detection
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            src_prev_q <= '0;
        end else begin
            src_prev_q <= src;
        end
    end

    // ************************************************************
    // pending flags
    // ************************************************************
    // rising edges and software sets; reserved bits reachable only by software
    assign pend_set = (src & ~src_prev_q) | (sw_set_valid ? sw_set_mask : '0);

    // fetch clears only the chosen entry
    always_comb begin
        pend_clr = '0;
        if (take) begin
            pend_clr[sel_idx] = 1'b1;
        end
    end

    // every flag holds independently, a new set beats the clear
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            pend_q <= '0;
        end else begin
            pend_q <= (pend_q & ~pend_clr) | pend_set;
        end
    end

    // ************************************************************
    // group lines and precedence
    // ************************************************************
    assign live = pend_q & irq_enable;

    // one line per group of eight
    always_comb begin
        for (int g = 0; g < `IRQX_NUM_GROUPS; g++) begin
            group_any[g] = |live[g*`IRQX_GROUP_SIZE +: `IRQX_GROUP_SIZE];
        end
    end

    // registered lines and highest-precedence line
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            lines_q     <= '0;
            top_valid_q <= 1'b0;
            top_line_q  <= '0;
        end else begin
            lines_q     <= group_any;
            top_valid_q <= |group_any;
            top_line_q  <= lowest_index({4'h0, group_any});
        end
    end

    // ************************************************************
    // bypass lines
    // ************************************************************
    // not grouped, only registered toward the processor
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            t2_q  <= 1'b0;
            t3_q  <= 1'b0;
            nmi_q <= 1'b0;
        end else begin
            t2_q  <= second_timer_irq;
            t3_q  <= third_timer_irq;
            nmi_q <= direct_nmi_irq;
        end
    end

    // ************************************************************
    // service selection
    // ************************************************************
    assign line_ok   = svc_line < 4'(`IRQX_NUM_GROUPS);
    assign line_bits = line_ok ? live[{svc_line, 3'b000} +: `IRQX_GROUP_SIZE] : 8'h00;
    assign sel_pos   = 3'(lowest_index({8'h00, line_bits}));
    assign sel_idx   = {svc_line, sel_pos};
    assign take      = svc_req && (state_q == irqx_pkg::ST_IDLE) && (|line_bits);

    // ************************************************************
    // vector storage
    // ************************************************************
    assign wr_dec = addr_to_idx(vec_wr_addr);

    irqx_vector_ram #(
        .DEPTH (`IRQX_NUM_IRQ),
        .VEC_W (VEC_W)
    ) u_vram (
        .core_clk (core_clk),
        .reset_n  (reset_n),
        .wr_en    (vec_wr_en && wr_dec[`IRQX_IDX_W]),
        .wr_idx   (wr_dec[`IRQX_IDX_W-1:0]),
        .wr_data  (vec_wr_data),
        .rd_en    (take),
        .rd_idx   (sel_idx),
        .rd_data  (ram_data)
    );

    // ************************************************************
    // service sequencer
    // ************************************************************
    // accept, read vector, answer: vector out two cycles after acceptance
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            state_q   <= irqx_pkg::ST_IDLE;
            src_idx_q <= '0;
        end else begin
            case (state_q)
                irqx_pkg::ST_IDLE: begin
                    if (take) begin
                        state_q   <= irqx_pkg::ST_FETCH;
                        src_idx_q <= sel_idx;
                    end
                end
                irqx_pkg::ST_FETCH: begin
                    state_q <= irqx_pkg::ST_IDLE;
                end
                default: begin
                    state_q <= irqx_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // answer registers
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            vec_valid_q  <= 1'b0;
            vec_none_q   <= 1'b0;
            vec_data_q   <= '0;
            vec_source_q <= '0;
        end else begin
            vec_valid_q <= (state_q == irqx_pkg::ST_FETCH);
            vec_none_q  <= svc_req && (state_q == irqx_pkg::ST_IDLE) && !(|line_bits);
            if (state_q == irqx_pkg::ST_FETCH) begin
                vec_data_q   <= ram_data;
                vec_source_q <= src_idx_q;
            end
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign grouped_cpu_irq_lines = lines_q;
    assign group_pending_flags   = pend_q;
    assign timer2_irq_to_cpu     = t2_q;
    assign timer3_irq_to_cpu     = t3_q;
    assign nmi_irq_to_cpu        = nmi_q;
    assign top_line_valid        = top_valid_q;
    assign top_line              = top_line_q;
    assign vec_valid             = vec_valid_q;
    assign vec_none              = vec_none_q;
    assign vec_data              = vec_data_q;
    assign vec_source            = vec_source_q;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    chk_fetch_latency: assert property (take |-> ##[1:FETCH_MAX_C] vec_valid_q)
        else $error("vector not delivered in time");

    chk_fetch_source: assert property (take |-> ##2 (vec_valid_q && vec_source_q == $past(sel_idx, 2)))
        else $error("delivered vector has wrong source");

    chk_group_line: assert property ((|live[7:0]) |=> lines_q[0])
        else $error("group one line not raised");

    chk_disabled_quiet: assert property ((live == '0) |=> (lines_q == '0))
        else $error("line raised with nothing enabled");

    chk_timer_latch: assert property ($rose(first_timer_irq) |=> pend_q[`IRQX_IDX_TIMER])
        else $error("timer request not latched");

    chk_fpu_source: assert property ($rose(fpu_overflow_event) |=> pend_q[`IRQX_IDX_FPU_OVF])
        else $error("fpu overflow not latched");

    chk_clear_fetch: assert property ((take && !pend_set[sel_idx]) |=> !pend_q[$past(sel_idx)])
        else $error("pending not cleared on fetch");

    chk_lowest_first: assert property (take |-> ((line_bits & ((8'h01 << sel_pos) - 8'h01)) == 8'h00))
        else $error("lower position skipped");

    chk_hold_eight: assert property ((pend_q[7:0] == 8'hFF && !take) |=> pend_q[7:0] == 8'hFF)
        else $error("pending request lost");

    chk_bypass_path: assert property ($rose(direct_nmi_irq) |=> (nmi_q && lines_q == $past(group_any)))
        else $error("nmi bypass wrong");

    chk_reserved_dead: assert property ((!sw_set_valid && !pend_q[2]) |=> !pend_q[2])
        else $error("reserved input raised by hardware");

    cov_fetch: cover property (take ##2 vec_valid_q);
    cov_none: cover property (vec_none_q);
    cov_full_group: cover property (pend_q[7:0] == 8'hFF);
    cov_sw_set: cover property (sw_set_valid ##1 lines_q[10]);

endmodule

// file: sim/irqx_cpu_model.sv
// processor-side model: services grouped lines and raises software flags
`timescale 1ns/1ps
`include "irqx_map.svh"

module irqx_cpu_model (
    input  wire logic                     core_clk,
    output logic                          svc_req,
    output logic [`IRQX_LINE_W-1:0]       svc_line,
    output logic                          sw_set_valid,
    output logic [`IRQX_NUM_IRQ-1:0]      sw_set_mask
);
    int stall = 0;  // idle cycles before each request, slow core

    // quiet bus at time zero
    initial begin
        svc_req = 1'b0;
        svc_line = 4'hF;
        sw_set_valid = 1'b0;
        sw_set_mask = '0;
    end

    // one service request; line chosen by software order
    task automatic service(input logic [3:0] line);
        repeat (stall) @(posedge core_clk);
        @(posedge core_clk);
        #1;
        svc_req = 1'b1;
        svc_line = line;
        @(posedge core_clk);
        #1;
        svc_req = 1'b0;
        svc_line = ~line;  // released line no longer shows the value
    endtask

    // software flag set for one cycle, any groups in the mask
    task automatic sw_set(input logic [95:0] mask);
        @(posedge core_clk);
        #1;
        sw_set_valid = 1'b1;
        sw_set_mask = mask;
        @(posedge core_clk);
        #1;
        sw_set_valid = 1'b0;
        sw_set_mask = ~mask;
    endtask
endmodule

// file: sim/irqx_expander_tb.sv
// self-checking bench for the grouped interrupt expander
`timescale 1ns/1ps
`include "irqx_map.svh"

module irqx_expander_tb;
    // ************************************************************
    // signals
    // ************************************************************
    typedef struct packed {
        logic        none;
        logic [6:0]  src;
        logic [31:0] data;
    } irqx_exp_t;
    logic        core_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [5:0]  g1_v = '0;     // converters, pins, timer, wake
    logic [7:0]  trip_v = '0;   // modulator trip events
    logic [7:0]  evt_v = '0;    // modulator normal events
    logic [1:0]  fpu_v = '0;    // overflow, underflow
    logic [95:0] other_v = '0;  // generic sources
    logic [2:0]  byp_v = '0;    // bypass inputs
    logic [95:0] enable = '1;   // per-input enables
    logic        wr_en = 1'b0;
    logic [15:0] wr_addr = 16'h0000;
    logic [31:0] wr_data = 32'h0000_0000;
    logic        svc_req, sw_set_valid;
    logic [3:0]  svc_line, top_line;
    logic [95:0] sw_set_mask, pend;
    logic [11:0] lines;
    logic        t2, t3, nmi, top_v, vec_valid, vec_none;
    logic [31:0] vec_data;
    logic [6:0]  vec_source;
    logic [31:0] exp_vec [96];  // model of the vector memory
    irqx_exp_t   exp_q [$];     // pending expected answers
    int          n_errors = 0;
    int          n_compared = 0;
    int          seed = 88825;
    int          src_idx [13] = '{0, 1, 3, 4, 6, 7, 8, 15, 16, 23, 94, 95, 32};

    always #25 core_clk = ~core_clk;

    irqx_cpu_model cpu (.core_clk(core_clk), .svc_req(svc_req), .svc_line(svc_line),
        .sw_set_valid(sw_set_valid), .sw_set_mask(sw_set_mask));

    irqx_expander dut (.core_clk(core_clk), .reset_n(reset_n), .converter_irq_a(g1_v[0]),
        .converter_irq_b(g1_v[1]), .ext_pin_irq_a(g1_v[2]), .ext_pin_irq_b(g1_v[3]),
        .first_timer_irq(g1_v[4]), .low_power_wake_irq(g1_v[5]), .modulator_trip_irq(trip_v),
        .modulator_event_irq(evt_v), .fpu_overflow_event(fpu_v[0]), .fpu_underflow_event(fpu_v[1]),
        .other_periph_irq(other_v), .second_timer_irq(byp_v[0]), .third_timer_irq(byp_v[1]),
        .direct_nmi_irq(byp_v[2]), .irq_enable(enable), .sw_set_valid(sw_set_valid),
        .sw_set_mask(sw_set_mask), .vec_wr_en(wr_en), .vec_wr_addr(wr_addr), .vec_wr_data(wr_data),
        .svc_req(svc_req), .svc_line(svc_line), .grouped_cpu_irq_lines(lines),
        .group_pending_flags(pend), .timer2_irq_to_cpu(t2), .timer3_irq_to_cpu(t3),
        .nmi_irq_to_cpu(nmi), .top_line_valid(top_v), .top_line(top_line), .vec_valid(vec_valid),
        .vec_none(vec_none), .vec_data(vec_data), .vec_source(vec_source));

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic tick();
        @(posedge core_clk);
        #1;
    endtask

    // compare and count
    task automatic check(input string what, input logic [95:0] exp, input logic [95:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask

    // vector write, data scrambled once released, one idle edge before the next write
    task automatic vwrite(input logic [15:0] addr, input logic [31:0] data);
        wr_en = 1'b1;
        wr_addr = addr;
        wr_data = data;
        tick();
        wr_en = 1'b0;
        wr_data = ~data;
        tick();
    endtask

    // one service with its expected answer, bounded wait
    task automatic serve(input logic [3:0] line, input logic none, input int src);
        exp_q.push_back('{none, src[6:0], exp_vec[src]});
        cpu.service(line);
        for (int k = 0; k < 8 && exp_q.size() != 0; k++) tick();
        check("answer latency", 96'h0, 96'(exp_q.size()));
    endtask

    // drive source k of the table to level v
    task automatic pulse(input int k, input logic v);
        case (k)
            0, 1, 2, 3, 4, 5: g1_v[k] = v;
            6: trip_v[0] = v;
            7: trip_v[7] = v;
            8: evt_v[0] = v;
            9: evt_v[7] = v;
            10, 11: fpu_v[k-10] = v;
            default: other_v[32] = v;
        endcase
    endtask

    // answers are matched against the oldest expectation
    always @(posedge core_clk) begin
        #2;
        if (vec_valid === 1'b1 || vec_none === 1'b1) begin
            if (exp_q.size() == 0) begin
                check("stray answer", 96'h0, 96'h1);
            end else begin
                irqx_exp_t e;
                e = exp_q.pop_front();
                check("vec_none", 96'(e.none), 96'(vec_none));
                if (!e.none) begin
                    check("vec_source", 96'(e.src), 96'(vec_source));
                    check("vec_data", 96'(e.data), 96'(vec_data));
                end
            end
        end
    end

    task automatic end_of_test();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // hang guard
    initial begin
        #(50 * 20000);
        n_errors++;
        end_of_test();
    end

    // ************************************************************
    // scenarios
    // ************************************************************
    initial begin
        repeat (8) tick();
        reset_n = 1'b1;
        check("pending after reset", 96'h0, pend);
        for (int i = 0; i < 96; i++) begin
            exp_vec[i] = $random(seed);
            vwrite(16'h0D40 + 16'(2 * i), exp_vec[i]);
        end
        // odd address and an address past the table that aliases entry 0: both ignored
        vwrite(16'h0D41, 32'hDEAD_BEEF);
        vwrite(16'h0E40, 32'hDEAD_BEEF);
        // named sources (trip and event bits 0 and 7 only) and generic input 32 land at their fixed places, then are fetched
        for (int k = 0; k < 13; k++) begin
            cpu.stall = k % 3;
            pulse(k, 1'b1);
            tick();
            pulse(k, 1'b0);
            tick();
            check("pending place", 96'h1 << src_idx[k], pend);
            check("group line", 96'(12'h001 << (src_idx[k] / 8)), 96'(lines));
            serve(4'(src_idx[k] / 8), 1'b0, src_idx[k]);
            check("pending cleared", 96'h0, pend);
        end
        cpu.stall = 0;
        // generic inputs at reserved position 2 and named position 0 never latch
        other_v[2] = 1'b1;
        other_v[0] = 1'b1;
        tick();
        tick();
        check("reserved latch", 96'h0, pend);
        other_v = '0;
        // three pending in one line, lowest disabled
        enable[0] = 1'b0;
        cpu.sw_set(96'h0B);
        tick();
        check("three pending", 96'h0B, pend);
        serve(4'h0, 1'b0, 1);
        serve(4'h0, 1'b0, 3);
        check("disabled hidden", 96'h0, 96'(lines));
        serve(4'h0, 1'b1, 0);
        enable[0] = 1'b1;
        serve(4'h0, 1'b0, 0);
        // line out of range answers with nothing
        serve(4'hC, 1'b1, 0);
        // all eight of line one pending at once, served in position order
        cpu.sw_set(96'hFF);
        tick();
        check("eight pending", 96'hFF, pend);
        for (int p = 0; p < 8; p++) begin
            serve(4'h0, 1'b0, p);
        end
        check("eight drained", 96'h0, pend);
        // lower group wins the top line
        cpu.sw_set(96'h1_0200);
        tick();
        check("top valid", 96'h1, 96'(top_v));
        check("top line", 96'h1, 96'(top_line));
        serve(4'h1, 1'b0, 9);
        serve(4'h2, 1'b0, 16);
        check("top idle", 96'h0, 96'(top_v));
        // bypass inputs go straight through, one cycle later
        byp_v = 3'h7;
        tick();
        check("bypass high", 96'h7, 96'({nmi, t3, t2}));
        check("bypass no group", 96'h0, 96'(lines));
        byp_v = 3'h0;
        tick();
        check("bypass low", 96'h0, 96'({nmi, t3, t2}));
        end_of_test();
    end
endmodule
